/* include/icr_map.svh */
// Constants of the interface configuration register bank: offsets,
// field positions, reset values and timing counts.
// Assumes an 8-bit serial register port with a 15-bit register address.
//
// Overview of operation
// - Soft-reset bit resets whole chip and registers.
// - Soft-reset bit clears itself after reset.
// - Soft reset finishes within 750 ns.
// - Streaming address decrements at 0, increments at 1.
// - Output pin indicator reads 1; dedicated data output.
// - Mode 0 normal, 3 power-down, 1-2 reserved.
// - Read-only 16-bit maker identity, fixed code.
// - Address hold keeps streaming address constant.
`ifndef ICR_MAP_SVH
`define ICR_MAP_SVH

// Register offsets
`define ICR_ADDR_SETUP       15'h0000
`define ICR_ADDR_POWER       15'h0002
`define ICR_ADDR_ID_LO       15'h000c
`define ICR_ADDR_ID_HI       15'h000d
`define ICR_ADDR_STREAM      15'h0010

// Reset values
`define ICR_SETUP_RST        8'h30
`define ICR_POWER_RST        8'h00
`define ICR_STREAM_RST       8'h00

// Field positions
`define ICR_SETUP_SRST_BIT   7
`define ICR_SETUP_ASCEND_BIT 5
`define ICR_SETUP_PIN_BIT    4
`define ICR_STREAM_HOLD_BIT  0

// Operating-state encodings
`define ICR_MODE_NORMAL      2'h0
`define ICR_MODE_PWRDN       2'h3

// Maker code; the value is arbitrary
`define ICR_MAKER_CODE       16'h5a3c

// Timing: longest soft-reset time in ns, clock period in ps
`define ICR_SRST_MAX_NS      750
`define ICR_CLK_PERIOD_PS    4000
`define ICR_SRST_MAX_CYCLES  ((`ICR_SRST_MAX_NS * 1000) / `ICR_CLK_PERIOD_PS)
// Reset pulse leaves two cycles for trigger and release
`define ICR_SRST_HOLD        (`ICR_SRST_MAX_CYCLES - 2)

`endif

/* include/icr_pkg.sv */
// Types of the interface configuration register bank.
// Assumes nothing beyond the constants header.
package icr_pkg;

  typedef logic [14:0] icr_addr_t;
  typedef logic [1:0]  icr_mode_t;

  // Serial frame phase, one-hot
  typedef enum logic [3:0] {
    ICR_PH_IDLE     = 4'b0001,
    ICR_PH_INSTR_HI = 4'b0010,
    ICR_PH_INSTR_LO = 4'b0100,
    ICR_PH_DATA     = 4'b1000
  } icr_phase_t;

endpackage : icr_pkg

/* design/icr_soft_reset.sv */
// Soft-reset sequencer: stretches a one-cycle trigger into a chip reset.
// Assumes the trigger comes from the register write decode.
`timescale 1ns/10ps
`include "icr_map.svh"
module icr_soft_reset #(
  parameter int HOLD = `ICR_SRST_HOLD
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Trigger and reset out
  input  wire logic i_trigger,
  output logic      o_active
);

  logic [15:0] count;

  // Count down the reset pulse; a trigger starts it afresh
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      count    <= 16'h0000;
      o_active <= 1'b0;
    end
    else if (i_trigger)
    begin
      count    <= 16'(HOLD);
      o_active <= 1'b1;
    end
    else if (count != 16'h0000)
    begin
      count    <= count - 16'h0001;
      o_active <= (count != 16'h0001);
    end
  end

endmodule : icr_soft_reset

/* design/icr_serial_port.sv */
// Serial port shifter: samples data on rising serial clock, shifts the
// read byte out on falling serial clock, most significant bit first.
// Assumes pins synchronous to i_clk and each serial clock phase at least
// four i_clk cycles long.
`timescale 1ns/10ps
module icr_serial_port (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // Serial pins
  input  wire logic       i_sclk,
  input  wire logic       i_csb_n,
  input  wire logic       i_sdi,
  output logic            o_sdo,
  output logic            o_sdo_oe,
  // Byte side
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte,
  input  wire logic       i_tx_load,
  input  wire logic [7:0] i_tx_byte
);

  logic       sclk_q;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] shift_out;

  // Edge detection while the frame is selected
  wire logic sclk_rise = i_sclk & ~sclk_q & ~i_csb_n;
  wire logic sclk_fall = ~i_sclk & sclk_q & ~i_csb_n;

  // Receive shifter, byte strobe on eighth bit
  always_ff @(posedge i_clk)
  begin
    if (i_srst || i_csb_n)
    begin
      bit_cnt    <= 3'h0;
      shift_in   <= 7'h00;
      o_rx_valid <= 1'b0;
      o_rx_byte  <= 8'h00;
    end
    else
    begin
      o_rx_valid <= sclk_rise && (bit_cnt == 3'h7);
      if (sclk_rise)
      begin
        bit_cnt  <= bit_cnt + 3'h1;
        shift_in <= {shift_in[5:0], i_sdi};
        if (bit_cnt == 3'h7)
          o_rx_byte <= {shift_in, i_sdi};
      end
    end
  end

  // Transmit shifter on the dedicated data output
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sclk_q    <= 1'b0;
      shift_out <= 8'h00;
      o_sdo     <= 1'b0;
      o_sdo_oe  <= 1'b0;
    end
    else
    begin
      sclk_q   <= i_sclk;
      o_sdo_oe <= ~i_csb_n;
      if (i_tx_load)
        shift_out <= i_tx_byte;
      else if (sclk_fall)
      begin
        o_sdo     <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

endmodule : icr_serial_port

/* design/icr_top.sv */
// Interface configuration register bank behind the serial register port.
// Holds the serial setup register, the power state, the maker identity
// and the streaming option, and drives the whole-chip soft reset.
// Assumes a host that frames each transaction with the select pin, sends
// a read flag and 15 address bits, then one or more data bytes.
`timescale 1ns/10ps
`include "icr_map.svh"
module icr_top #(
  parameter logic [15:0] MAKER_CODE = `ICR_MAKER_CODE, // Arbitrary value
  parameter int          SRST_HOLD  = `ICR_SRST_HOLD
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Serial register port
  input  wire logic        i_sclk,
  input  wire logic        i_csb_n,
  input  wire logic        i_sdi,
  output logic             o_sdo,
  output logic             o_sdo_oe,
  // Chip control
  output logic             o_chip_reset,
  output logic             o_power_down,
  output icr_pkg::icr_mode_t o_power_mode
);
  import icr_pkg::*;

  logic       soft_rst;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic [7:0] setup;
  logic [7:0] power;
  logic [7:0] stream;
  logic       rd_mode;
  logic [6:0] addr_hi;
  icr_addr_t  addr;
  icr_phase_t phase;
  icr_phase_t next_phase;
  logic       tx_load;
  logic [7:0] read_data;
  logic       srst_trigger;

  // Registers and framing fall back to defaults on either reset
  wire logic reg_rst = i_srst | soft_rst;

  // Serial shifter
  icr_serial_port u_port (
    .i_clk      (i_clk),
    .i_srst     (reg_rst),
    .i_sclk     (i_sclk),
    .i_csb_n    (i_csb_n),
    .i_sdi      (i_sdi),
    .o_sdo      (o_sdo),
    .o_sdo_oe   (o_sdo_oe),
    .o_rx_valid (rx_valid),
    .o_rx_byte  (rx_byte),
    .i_tx_load  (tx_load),
    .i_tx_byte  (read_data)
  );

  // Soft-reset pulse generator
  icr_soft_reset #(
    .HOLD (SRST_HOLD)
  ) u_srst (
    .i_clk     (i_clk),
    .i_srst    (i_srst),
    .i_trigger (srst_trigger),
    .o_active  (soft_rst)
  );

  // Phase decode
  wire logic in_hi   = (phase == ICR_PH_INSTR_HI);
  wire logic in_lo   = (phase == ICR_PH_INSTR_LO);
  wire logic in_data = (phase == ICR_PH_DATA);

  // Streaming options
  wire logic ascend = setup[`ICR_SETUP_ASCEND_BIT];
  wire logic hold   = stream[`ICR_STREAM_HOLD_BIT];

  // Next address of a stream: held, incremented or decremented
  wire icr_addr_t addr_up   = icr_addr_t'(addr + 15'h0001);
  wire icr_addr_t addr_down = icr_addr_t'(addr - 15'h0001);
  wire icr_addr_t stepped   = hold ? addr : (ascend ? addr_up : addr_down);

  // Address completed by the second instruction byte
  wire icr_addr_t base_addr = {addr_hi, rx_byte};

  // Write strobe and soft-reset trigger
  wire logic wr_strobe    = rx_valid && in_data && !rd_mode;
  wire logic wr_setup     = wr_strobe && (addr == `ICR_ADDR_SETUP);
  wire logic wr_power     = wr_strobe && (addr == `ICR_ADDR_POWER);
  wire logic wr_stream    = wr_strobe && (addr == `ICR_ADDR_STREAM);
  assign srst_trigger = wr_setup && rx_byte[`ICR_SETUP_SRST_BIT];

  // Read byte loaded after the address and after each streamed byte
  assign tx_load = rx_valid && rd_mode && (in_lo || in_data);
  wire icr_addr_t load_addr = in_lo ? base_addr : stepped;

  // Read-back values; the output pin indicator is always one
  wire logic [7:0] setup_rd = {setup[7:5], 1'b1, setup[3:0]};

  // Read multiplexer; unmapped addresses read zero
  assign read_data =
    (load_addr == `ICR_ADDR_SETUP)  ? setup_rd          :
    (load_addr == `ICR_ADDR_POWER)  ? power             :
    (load_addr == `ICR_ADDR_ID_LO)  ? MAKER_CODE[7:0]   :
    (load_addr == `ICR_ADDR_ID_HI)  ? MAKER_CODE[15:8]  :
    (load_addr == `ICR_ADDR_STREAM) ? stream            :
                                      8'h00;

  // Frame phase: wait for deselect after reset, then parse bytes
  always_comb
  begin
    next_phase = phase;
    case (phase)
      ICR_PH_IDLE:
        if (i_csb_n)
          next_phase = ICR_PH_INSTR_HI;
      ICR_PH_INSTR_HI:
        if (rx_valid)
          next_phase = ICR_PH_INSTR_LO;
      ICR_PH_INSTR_LO:
        if (i_csb_n)
          next_phase = ICR_PH_INSTR_HI;
        else if (rx_valid)
          next_phase = ICR_PH_DATA;
      ICR_PH_DATA:
        if (i_csb_n)
          next_phase = ICR_PH_INSTR_HI;
      default:
        next_phase = ICR_PH_IDLE;
    endcase
  end

  // Phase register
  always_ff @(posedge i_clk)
  begin
    if (reg_rst)
      phase <= ICR_PH_IDLE;
    else
      phase <= next_phase;
  end

  // Instruction capture and address stepping
  always_ff @(posedge i_clk)
  begin
    if (reg_rst)
    begin
      rd_mode <= 1'b0;
      addr_hi <= 7'h00;
      addr    <= 15'h0000;
    end
    else if (rx_valid && in_hi)
    begin
      rd_mode <= rx_byte[7];
      addr_hi <= rx_byte[6:0];
    end
    else if (rx_valid && in_lo)
      addr <= base_addr;
    else if (rx_valid && in_data)
      addr <= stepped;
  end

  // Serial setup register; the reset bit is cleared by the reset it starts
  always_ff @(posedge i_clk)
  begin
    if (reg_rst)
      setup <= `ICR_SETUP_RST;
    else if (wr_setup)
      setup <= rx_byte;
  end

  // Power state and streaming option registers
  always_ff @(posedge i_clk)
  begin
    if (reg_rst)
    begin
      power  <= `ICR_POWER_RST;
      stream <= `ICR_STREAM_RST;
    end
    else
    begin
      if (wr_power)
        power <= rx_byte;
      if (wr_stream)
        stream <= rx_byte;
    end
  end

  // Power-down output; reserved modes behave as normal operation
  always_ff @(posedge i_clk)
  begin
    if (reg_rst)
      o_power_down <= 1'b0;
    else
      o_power_down <= (power[1:0] == `ICR_MODE_PWRDN);
  end

  // Chip-level outputs
  assign o_power_mode = power[1:0];
  assign o_chip_reset = soft_rst;

endmodule : icr_top

/* verification/icr_chk.sv */
// Pin checker of the register bank, bound to icr_top.
// Assumes the reset pulse length is handed on as SRST_HOLD.
`timescale 1ns/10ps
module icr_chk #(
  parameter int SRST_HOLD = 8
) (
  // Clock and reset
  input wire logic               i_clk,
  input wire logic               i_srst,
  // Serial pins
  input wire logic               i_sclk,
  input wire logic               i_csb_n,
  input wire logic               i_sdi,
  input wire logic               o_sdo,
  input wire logic               o_sdo_oe,
  // Chip control
  input wire logic               o_chip_reset,
  input wire logic               o_power_down,
  input wire icr_pkg::icr_mode_t o_power_mode
);
  import icr_pkg::*;
  int cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Cycles the chip reset has stood high
  always_ff @(posedge i_clk)
    cnt <= o_chip_reset ? cnt + 1 : 0;
  chk_pd_follows: assert property (!o_chip_reset |->
    o_power_down == ($past(o_power_mode) == 2'h3)) else $error("power down wrong");
  chk_oe_follows: assert property (o_sdo_oe ==
    (!$past(i_csb_n) && !$past(o_chip_reset) && !$past(i_srst)))
    else $error("output enable wrong");
  chk_mode_frame: assert property ($changed(o_power_mode) |->
    !$past(i_csb_n) || $past(o_chip_reset)) else $error("mode changed outside frame");
  chk_rst_frame: assert property ($rose(o_chip_reset) |-> !$past(i_csb_n))
    else $error("reset without frame");
  chk_rst_clears: assert property ($rose(o_chip_reset) |->
    ##2 o_power_mode == 2'h0 && !o_power_down) else $error("reset left mode");
  chk_rst_len: assert property ($fell(o_chip_reset) |-> cnt == SRST_HOLD)
    else $error("reset pulse length wrong");
  chk_rst_once: assert property ($fell(o_chip_reset) |=> !o_chip_reset [*4])
    else $error("reset retriggered");
  chk_sdo_edge: assert property (disable iff (i_srst || o_chip_reset)
    $changed(o_sdo) && !$past(i_csb_n, 2) |-> $past(i_sclk, 2) && !$past(i_sclk))
    else $error("data out moved off edge");
  // Main scenarios
  cover property ($rose(o_chip_reset));
  cover property ($rose(o_power_down));
  cover property (o_sdo && o_sdo_oe);
endmodule : icr_chk

bind icr_top icr_chk #(.SRST_HOLD(SRST_HOLD)) u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_sclk(i_sclk), .i_csb_n(i_csb_n),
  .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_chip_reset(o_chip_reset),
  .o_power_down(o_power_down), .o_power_mode(o_power_mode));

/* verification/icr_host.sv */
// Serial host model: frames register transfers with the select pin.
// Assumes the bench calls frame() and i_clk is the bank's clock.
`timescale 1ns/10ps
module icr_host (
  // Clock
  input  wire logic i_clk,
  // Serial pins
  output logic      o_sclk,
  output logic      o_csb_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  // Idle pins
  initial
  begin
    o_sclk  = 1'b0;
    o_csb_n = 1'b1;
    o_sdi   = 1'b0;
  end
  // Wait clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // One framed transfer; data bytes right aligned, first byte highest
  task automatic frame(input logic [15:0] ins, input int nb,
                       input logic [63:0] wd, output logic [63:0] rd);
    rd = '0;
    tick(1);
    o_csb_n <= 1'b0;
    for (int i = 0; i < 16 + 8 * nb; i++)
    begin
      tick(1);
      o_sclk <= 1'b0;
      o_sdi  <= (i < 16) ? ins[15 - i] : wd[8 * nb + 15 - i];
      tick(4);
      rd = {rd[62:0], i_sdo};
      o_sclk <= 1'b1;
      tick(3);
    end
    tick(1);
    o_sclk  <= 1'b0;
    o_csb_n <= 1'b1;
    o_sdi   <= ~o_sdi; // Released line shows no stale bit
    tick(2);
  endtask : frame
endmodule : icr_host

/* verification/testbench.sv */
// Self-checking bench of the register bank with a serial host model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
module testbench;
  import icr_pkg::*;
  localparam logic [15:0] CODE = 16'h9e27; // Arbitrary value
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        sclk, csb_n, sdi, o_sdo, o_sdo_oe, o_chip_reset, o_power_down;
  icr_mode_t   o_power_mode;
  logic [31:0] seed = 32'h3db5;
  logic [63:0] rd;
  logic [7:0]  setup = 8'h30, pwr = 8'h0, strm = 8'h0;
  int          n_errors = 0, check_count = 0, cyc = 0, t;
  icr_top #(.MAKER_CODE(CODE), .SRST_HOLD(8)) uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_csb_n(csb_n), .i_sdi(sdi),
    .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_chip_reset(o_chip_reset),
    .o_power_down(o_power_down), .o_power_mode(o_power_mode));
  // Undriven data output shows the inverse of its last bit
  icr_host host (.i_clk(i_clk), .o_sclk(sclk), .o_csb_n(csb_n), .o_sdi(sdi),
    .i_sdo(o_sdo_oe ? o_sdo : ~o_sdo));
  // Clock and hang limit
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected read value of one byte
  function automatic logic [7:0] exp_rd(input logic [14:0] a);
    case (a)
      15'h0:   return {setup[7:5], 1'b1, setup[3:0]};
      15'h2:   return pwr;
      15'hc:   return CODE[7:0];
      15'hd:   return CODE[15:8];
      15'h10:  return strm;
      default: return 8'h0;
    endcase
  endfunction : exp_rd
  // Address after one streamed byte
  function automatic logic [14:0] nxt(input logic [14:0] a);
    return strm[0] ? a : setup[5] ? a + 15'h1 : a - 15'h1;
  endfunction : nxt
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t pin %h expected %h", $time, got, exp);
    end
  endtask : cmp_pin
  // Streaming read, each byte compared
  task automatic rd_chk(input logic [14:0] a, input int nb);
    host.frame({1'b1, a}, nb, 64'h0, rd);
    for (int k = nb - 1; k >= 0; k--)
    begin
      cmp_byte(rd[8 * k +: 8], exp_rd(a));
      a = nxt(a);
    end
  endtask : rd_chk
  task automatic wr(input logic [14:0] a, input int nb, input logic [63:0] d);
    host.frame({1'b0, a}, nb, d, rd);
  endtask : wr
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // Main sequence
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_clk);
    for (int a = 0; a < 17; a++)
      rd_chk(a[14:0], 1);
    seed = lfsr(seed);
    wr(15'hc, 2, {48'h0, seed[15:0]});
    wr(15'h0, 1, 64'h0);
    setup = 8'h00;
    rd_chk(15'hd, 2);
    rd_chk(15'h0, 1);
    wr(15'h0, 1, 64'h20);
    setup = 8'h20;
    rd_chk(15'hc, 2);
    wr(15'h10, 1, 64'h1);
    strm = 8'h01;
    rd_chk(15'hc, 3);
    for (int m = 0; m < 4; m++)
    begin
      seed = lfsr(seed);
      wr(15'h2, 2, {48'h0, 6'h0, seed[1:0], 6'h0, m[1:0]});
      pwr = {6'h0, m[1:0]};
      @(negedge i_clk);
      cmp_pin(o_power_mode, m[1:0]);
      cmp_pin({1'b0, o_power_down}, {1'b0, m == 3});
      rd_chk(15'h2, 1);
    end
    wr(15'h0, 1, 64'ha0);
    @(negedge i_clk);
    cmp_pin({1'b0, o_chip_reset}, 2'h1);
    t = 0;
    while (o_chip_reset === 1'b1 && t < 200)
    begin
      @(negedge i_clk);
      t++;
    end
    cmp_pin({1'b0, t < 187}, 2'h1);
    repeat (187) @(posedge i_clk);
    setup = 8'h30;
    pwr = 8'h0;
    strm = 8'h0;
    cmp_pin(o_power_mode, 2'h0);
    rd_chk(15'h0, 3);
    rd_chk(15'h10, 1);
    conclude();
  end
endmodule : testbench
